// File: rtl/eeprom_seq_defines.svh
`ifndef EEPROM_SEQ_DEFINES_SVH
`define EEPROM_SEQ_DEFINES_SVH

// =====================================================================
// command words
`define WORD_ENTER 16'hDCBA
`define WORD_NOP 16'hFFFF
`define WORD_WRITE_BIT 15
`define WORD_ADDR_MSB 11
`define WORD_ADDR_LSB 4

// =====================================================================
// register offsets
`define OFS_FAIL_IND 8'h01
`define OFS_SM_POWER 8'h25
`define OFS_EE_CMD 8'h3E
`define OFS_LINE_FIRST 8'h40
`define OFS_LINE_LAST 8'h51

// =====================================================================
// operation codes at the eeprom command line
`define OP_PROG_ZEROS 16'h024E
`define OP_PROG_ONES 16'h024F
`define OP_REFRESH 16'h024C
`define OP_MARGIN_ZEROS 16'h0045
`define OP_MARGIN_ONES 16'h0044
`define OP_MARGIN_STOP 16'h0080

// =====================================================================
// field positions and reset values
`define SM_POWER_DOWN_BIT 15
`define FAIL_IND_RESET 16'h0001
`define SM_POWER_RESET 16'h0000
`define LINE_COUNT 18

`endif

// File: rtl/eeprom_seq_pkg.sv
package eeprom_seq_pkg;

  typedef enum logic [1:0] {
    WALK_IDLE,
    WALK_READ,
    WALK_WRITE
  } walk_state_e;

  typedef enum logic [1:0] {
    WALK_REFRESH,
    WALK_PROGRAM,
    WALK_MARGIN
  } walk_kind_e;

  typedef enum logic [2:0] {
    ARM_NONE,
    ARM_PROG_ZEROS,
    ARM_PROG_ONES,
    ARM_MARGIN_ZEROS,
    ARM_MARGIN_ONES
  } arm_e;

endpackage

// File: rtl/line_memory.sv
`timescale 1ns/100ps

// =====================================================================
// line memory: one write port, registered read data
module line_memory #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 18,
  parameter int AW = 5
) (
  input wire logic clk_in, // clock
  input wire logic wr_en_in, // write strobe
  input wire logic [AW-1:0] wr_addr_in, // write line
  input wire logic [WIDTH-1:0] wr_data_in, // write data
  input wire logic [AW-1:0] rd_addr_in, // read line
  output logic [WIDTH-1:0] rd_data_out // read data, one cycle later
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    rd_data_out <= mem_q[rd_addr_in];
  end

endmodule

// File: rtl/eeprom_program_margin_sequencer.sv
// How it works
// - two command words arm a program step; the voltage pulse commits it
// - line configuration lives in nonvolatile lines, loaded at reset; registers 01 and 25 reset to fixed values
// - read command carries line address in bits 11:4, 40 to 51
// - read result answers on the next word, typically FFFF
// - write word 8400 then data loads line content to program
// - write word 83E0 then an operation code starts eeprom operations
// - code 024E arms programming of zero bits
// - code 024F arms programming of one bits
// - code 024C reloads nonvolatile lines into device registers
// - codes 0045/0044 arm margin refresh, 0080 stops margin test
// - ones test: threshold above margin loads one, below loads zero
// - zeros test: margin below threshold loads one, above loads zero
`timescale 1ns/100ps
`include "eeprom_seq_defines.svh"

module eeprom_program_margin_sequencer #(
  parameter int LINES = `LINE_COUNT,
  parameter int AW = 5
) (
  input wire logic clk_in, // 250 MHz clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic [15:0] cmd_word_in, // word from link block
  input wire logic cmd_valid_in, // one-cycle strobe with word
  input wire logic prog_pulse_in, // programming voltage present on pin, async
  input wire logic [15:0] margin_above_in, // per cell: threshold above margin voltage
  input wire logic fault_in, // internal failure request
  output logic [15:0] resp_word_out, // answer word
  output logic resp_valid_out, // one-cycle strobe with answer
  output logic entered_out, // interface entered
  output logic sm_power_down_out, // supervisory state machine powered down
  output logic fail_ind_en_out, // failure indication enabled
  output logic busy_out, // line walk running
  output logic margin_mode_out, // margin test armed
  output logic [AW-1:0] margin_line_out, // line under refresh
  output logic overcurrent_output_two_o_out, // pin level when driven
  output logic overcurrent_output_two_oe_out // pin driven low
);

  logic entered_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [15:0] fail_ind_q;
  logic [15:0] sm_power_q;
  eeprom_seq_pkg::arm_e arm_q;
  eeprom_seq_pkg::walk_state_e walk_q;
  eeprom_seq_pkg::walk_kind_e kind_q;
  logic [AW-1:0] line_q;
  logic rd_pend_q;
  logic rd_cap_q;
  logic rd_hit_q;
  logic [15:0] rd_hold_q;
  logic [15:0] rd_reg_q;
  logic [2:0] pulse_sync_q;
  logic oe_q;
  logic take;
  logic pulse_rise;
  logic [7:0] word_addr;
  logic [7:0] rd_addr_q;
  logic [AW-1:0] host_line;
  logic [AW-1:0] sh_raddr;
  logic [15:0] nvm_rdata;
  logic [15:0] sh_rdata;
  logic nvm_we;
  logic [15:0] nvm_wdata;
  logic sh_we;
  logic [AW-1:0] sh_waddr;
  logic [15:0] sh_wdata;
  logic prog_ones_q;
  logic margin_q;

  // =====================================================================
  // helpers
  function automatic logic is_line(input logic [7:0] a);
    return (a >= `OFS_LINE_FIRST) && (a <= `OFS_LINE_LAST);
  endfunction

  function automatic logic [AW-1:0] line_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - `OFS_LINE_FIRST;
    return d[AW-1:0];
  endfunction

  // words are ignored while a walk owns the memories
  assign take = cmd_valid_in && (walk_q == eeprom_seq_pkg::WALK_IDLE);
  assign word_addr = cmd_word_in[`WORD_ADDR_MSB:`WORD_ADDR_LSB];
  assign host_line = line_of(rd_addr_q);
  assign pulse_rise = pulse_sync_q[1] && !pulse_sync_q[2];

  // =====================================================================
  // programming voltage synchroniser
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pulse_sync_q <= 3'h0;
    end
    else
    begin
      pulse_sync_q <= {pulse_sync_q[1:0], prog_pulse_in};
    end
  end

  // =====================================================================
  // command word decode
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      entered_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end
    else if (take)
    begin
      rd_pend_q <= 1'b0;
      if (!entered_q)
      begin
        entered_q <= (cmd_word_in == `WORD_ENTER);
      end
      else if (wr_pend_q)
      begin
        wr_pend_q <= 1'b0;
      end
      else if (cmd_word_in == `WORD_NOP)
      begin
        wr_pend_q <= 1'b0;
      end
      else if (cmd_word_in[`WORD_WRITE_BIT])
      begin
        wr_pend_q <= 1'b1;
        wr_addr_q <= word_addr;
      end
      else
      begin
        rd_pend_q <= 1'b1;
        rd_addr_q <= word_addr;
      end
    end
  end

  // =====================================================================
  // read pipeline: address, registered memory, hold for next slot
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_cap_q <= 1'b0;
      rd_hit_q <= 1'b0;
      rd_reg_q <= 16'h0000;
      rd_hold_q <= 16'h0000;
    end
    else
    begin
      rd_cap_q <= rd_pend_q && take == 1'b0;
      rd_hit_q <= is_line(rd_addr_q);
      if (rd_addr_q == `OFS_FAIL_IND)
      begin
        rd_reg_q <= fail_ind_q;
      end
      else if (rd_addr_q == `OFS_SM_POWER)
      begin
        rd_reg_q <= sm_power_q;
      end
      else
      begin
        rd_reg_q <= 16'h0000;
      end
      if (rd_cap_q)
      begin
        rd_hold_q <= rd_hit_q ? sh_rdata : rd_reg_q;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      resp_word_out <= 16'h0000;
      resp_valid_out <= 1'b0;
    end
    else
    begin
      resp_valid_out <= take && entered_q;
      if (take && entered_q)
      begin
        resp_word_out <= rd_hold_q;
      end
    end
  end

  // =====================================================================
  // control registers and operation arming
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fail_ind_q <= `FAIL_IND_RESET;
      sm_power_q <= `SM_POWER_RESET;
      arm_q <= eeprom_seq_pkg::ARM_NONE;
      margin_q <= 1'b0;
    end
    else if (take && entered_q && wr_pend_q)
    begin
      if (wr_addr_q == `OFS_FAIL_IND)
      begin
        fail_ind_q <= cmd_word_in;
      end
      if (wr_addr_q == `OFS_SM_POWER)
      begin
        sm_power_q <= cmd_word_in;
      end
      if (wr_addr_q == `OFS_EE_CMD)
      begin
        case (cmd_word_in)
          `OP_PROG_ZEROS: arm_q <= eeprom_seq_pkg::ARM_PROG_ZEROS;
          `OP_PROG_ONES: arm_q <= eeprom_seq_pkg::ARM_PROG_ONES;
          `OP_MARGIN_ZEROS: arm_q <= eeprom_seq_pkg::ARM_MARGIN_ZEROS;
          `OP_MARGIN_ONES: arm_q <= eeprom_seq_pkg::ARM_MARGIN_ONES;
          `OP_MARGIN_STOP: arm_q <= eeprom_seq_pkg::ARM_NONE;
          default: arm_q <= arm_q;
        endcase
        // registered copy of the margin arming, so the output comes from a flop
        if (cmd_word_in == `OP_MARGIN_ZEROS || cmd_word_in == `OP_MARGIN_ONES)
        begin
          margin_q <= 1'b1;
        end
        else if (cmd_word_in == `OP_PROG_ZEROS || cmd_word_in == `OP_PROG_ONES ||
                 cmd_word_in == `OP_MARGIN_STOP)
        begin
          margin_q <= 1'b0;
        end
      end
    end
    else if (walk_q == eeprom_seq_pkg::WALK_IDLE && pulse_rise &&
             (arm_q == eeprom_seq_pkg::ARM_PROG_ZEROS ||
              arm_q == eeprom_seq_pkg::ARM_PROG_ONES))
    begin
      arm_q <= eeprom_seq_pkg::ARM_NONE;
    end
  end

  // =====================================================================
  // line walk: program, refresh or margin refresh of every line
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      walk_q <= eeprom_seq_pkg::WALK_READ;
      kind_q <= eeprom_seq_pkg::WALK_REFRESH;
      line_q <= '0;
    end
    else
    begin
      case (walk_q)
        eeprom_seq_pkg::WALK_IDLE:
        begin
          line_q <= '0;
          if (take && entered_q && wr_pend_q && wr_addr_q == `OFS_EE_CMD &&
              cmd_word_in == `OP_REFRESH)
          begin
            walk_q <= eeprom_seq_pkg::WALK_READ;
            kind_q <= eeprom_seq_pkg::WALK_REFRESH;
          end
          else if (pulse_rise && (arm_q == eeprom_seq_pkg::ARM_PROG_ZEROS ||
                                  arm_q == eeprom_seq_pkg::ARM_PROG_ONES))
          begin
            walk_q <= eeprom_seq_pkg::WALK_READ;
            kind_q <= eeprom_seq_pkg::WALK_PROGRAM;
          end
          else if (pulse_rise && (arm_q == eeprom_seq_pkg::ARM_MARGIN_ZEROS ||
                                  arm_q == eeprom_seq_pkg::ARM_MARGIN_ONES))
          begin
            walk_q <= eeprom_seq_pkg::WALK_READ;
            kind_q <= eeprom_seq_pkg::WALK_MARGIN;
          end
        end
        eeprom_seq_pkg::WALK_READ:
        begin
          walk_q <= eeprom_seq_pkg::WALK_WRITE;
        end
        eeprom_seq_pkg::WALK_WRITE:
        begin
          if (line_q == AW'(LINES - 1))
          begin
            walk_q <= eeprom_seq_pkg::WALK_IDLE;
          end
          else
          begin
            walk_q <= eeprom_seq_pkg::WALK_READ;
            line_q <= line_q + 1'b1;
          end
        end
        default: walk_q <= eeprom_seq_pkg::WALK_IDLE;
      endcase
    end
  end

  // =====================================================================
  // memory write muxing
  always_comb
  begin
    nvm_we = 1'b0;
    nvm_wdata = nvm_rdata;
    sh_we = 1'b0;
    sh_waddr = line_q;
    sh_wdata = nvm_rdata;
    if (walk_q == eeprom_seq_pkg::WALK_WRITE)
    begin
      case (kind_q)
        eeprom_seq_pkg::WALK_PROGRAM:
        begin
          nvm_we = 1'b1;
          // zeros clear where line content is zero, ones set where it is one
          nvm_wdata = prog_ones_q ? (nvm_rdata | sh_rdata) : (nvm_rdata & sh_rdata);
        end
        eeprom_seq_pkg::WALK_MARGIN:
        begin
          sh_we = 1'b1;
          sh_wdata = margin_above_in;
        end
        default:
        begin
          sh_we = 1'b1;
        end
      endcase
    end
    else if (take && entered_q && wr_pend_q && is_line(wr_addr_q))
    begin
      sh_we = 1'b1;
      sh_waddr = line_of(wr_addr_q);
      sh_wdata = cmd_word_in;
    end
  end

  // remembers which program step the running walk performs
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prog_ones_q <= 1'b0;
    end
    else if (walk_q == eeprom_seq_pkg::WALK_IDLE && pulse_rise)
    begin
      prog_ones_q <= (arm_q == eeprom_seq_pkg::ARM_PROG_ONES);
    end
  end

  assign sh_raddr = (walk_q == eeprom_seq_pkg::WALK_IDLE) ? host_line : line_q;

  line_memory #(.WIDTH(16), .DEPTH(LINES), .AW(AW)) u_nvm (
    .clk_in(clk_in),
    .wr_en_in(nvm_we),
    .wr_addr_in(line_q),
    .wr_data_in(nvm_wdata),
    .rd_addr_in(line_q),
    .rd_data_out(nvm_rdata)
  );

  line_memory #(.WIDTH(16), .DEPTH(LINES), .AW(AW)) u_shadow (
    .clk_in(clk_in),
    .wr_en_in(sh_we),
    .wr_addr_in(sh_waddr),
    .wr_data_in(sh_wdata),
    .rd_addr_in(sh_raddr),
    .rd_data_out(sh_rdata)
  );

  // =====================================================================
  // open-drain failure output, silenced by the failure indication enable
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      oe_q <= 1'b0;
      busy_out <= 1'b1;
    end
    else
    begin
      oe_q <= fault_in && fail_ind_q[0];
      busy_out <= (walk_q != eeprom_seq_pkg::WALK_IDLE);
    end
  end

  assign overcurrent_output_two_oe_out = oe_q;
  assign overcurrent_output_two_o_out = 1'b0 & oe_q;
  assign entered_out = entered_q;
  assign sm_power_down_out = sm_power_q[`SM_POWER_DOWN_BIT];
  assign fail_ind_en_out = fail_ind_q[0];
  assign margin_mode_out = margin_q;
  assign margin_line_out = line_q;

endmodule

// File: dv/eeprom_seq_checker_sva.sv
`timescale 1ns/100ps
`include "eeprom_seq_defines.svh"

// ==========================================
// port checker
module eeprom_seq_checker #(
  parameter int LINES = 18
) (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic [15:0] cmd_word_in, // word
  input wire logic cmd_valid_in, // word strobe
  input wire logic fault_in, // failure request
  input wire logic resp_valid_out, // answer strobe
  input wire logic entered_out, // entered
  input wire logic sm_power_down_out, // power down
  input wire logic fail_ind_en_out, // failure indication
  input wire logic busy_out, // walk running
  input wire logic margin_mode_out, // margin armed
  input wire logic [4:0] margin_line_out, // walked line
  input wire logic overcurrent_output_two_o_out, // pin level
  input wire logic overcurrent_output_two_oe_out // pin enable
);
  logic [7:0] busy_cnt_q;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_cnt_q <= 8'h00;
    end
    else
    begin
      busy_cnt_q <= busy_out ? busy_cnt_q + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_take(logic [15:0] w);
    cmd_valid_in && cmd_word_in == w && !busy_out;
  endsequence

  sequence s_write(logic [15:0] a, logic [15:0] d);
    (entered_out and s_take(a)) ##1 !cmd_valid_in [*3] ##1 s_take(d);
  endsequence

  a_enter_word: assert property (s_take(`WORD_ENTER) |=> entered_out)
    else $error("enter word not taken");
  a_entered_stays: assert property (entered_out |=> entered_out)
    else $error("entered dropped");
  a_power_down: assert property (s_write(16'h8250, 16'h8000) |=> sm_power_down_out)
    else $error("power down not set");
  a_fail_disable: assert property (s_write(16'h8010, 16'h0000) |=> !fail_ind_en_out)
    else $error("failure indication still on");
  a_pin_follows: assert property (
    overcurrent_output_two_oe_out == $past(fault_in && fail_ind_en_out))
    else $error("pin enable wrong");
  a_pin_low_only: assert property (!overcurrent_output_two_o_out)
    else $error("pin driven high");
  a_answer_cause: assert property (resp_valid_out |-> $past(cmd_valid_in && entered_out))
    else $error("answer without word");
  a_answer_pulse: assert property (resp_valid_out |=> !resp_valid_out)
    else $error("answer strobe too long");
  a_margin_arm: assert property ((s_write(16'h83E0, `OP_MARGIN_ONES) or
    s_write(16'h83E0, `OP_MARGIN_ZEROS)) |=> margin_mode_out)
    else $error("margin not armed");
  a_margin_stop: assert property (s_write(16'h83E0, `OP_MARGIN_STOP) |=> !margin_mode_out)
    else $error("margin not stopped");
  a_walk_bounded: assert property (busy_cnt_q < 8'h30)
    else $error("walk too long");
  a_line_range: assert property (busy_out |-> margin_line_out < LINES)
    else $error("walk line out of range");
endmodule

bind eeprom_program_margin_sequencer eeprom_seq_checker #(.LINES(LINES)) chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_word_in(cmd_word_in),
  .cmd_valid_in(cmd_valid_in), .fault_in(fault_in), .resp_valid_out(resp_valid_out),
  .entered_out(entered_out), .sm_power_down_out(sm_power_down_out),
  .fail_ind_en_out(fail_ind_en_out), .busy_out(busy_out), .margin_mode_out(margin_mode_out),
  .margin_line_out(margin_line_out),
  .overcurrent_output_two_o_out(overcurrent_output_two_o_out),
  .overcurrent_output_two_oe_out(overcurrent_output_two_oe_out));

// File: dv/eeprom_host_model.sv
`timescale 1ns/100ps

// ==========================================
// programmer driving command words and the pin
module eeprom_host_model (
  input wire logic clk_in, // clock
  input wire logic [15:0] resp_word_in, // answer word
  input wire logic resp_valid_in, // answer strobe
  input wire logic busy_in, // walk running
  output logic [15:0] cmd_word_out, // word
  output logic cmd_valid_out, // word strobe
  output logic prog_pulse_out // programming voltage
);
  initial
  begin
    cmd_word_out = 16'hFFFF;
    cmd_valid_out = 1'b0;
    prog_pulse_out = 1'b0;
  end

  // one 16-bit word; the one-cycle answer is sampled just after the edge that takes the word
  task automatic send(input logic [15:0] w, output logic got, output logic [15:0] ans);
    @(posedge clk_in);
    cmd_word_out <= w;
    cmd_valid_out <= 1'b1;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_word_out <= ~w;
    #1;
    got = resp_valid_in;
    ans = resp_word_in;
    @(posedge clk_in);
    @(posedge clk_in);
  endtask

  // access word then its data word
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    logic g;
    logic [15:0] r;
    send(a, g, r);
    send(d, g, r);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (!busy_in && n < 8)
    begin
      @(posedge clk_in);
      n++;
    end
    while (busy_in && n < 200)
    begin
      @(posedge clk_in);
      n++;
    end
  endtask

  // shortened pulse; the device commits only on it
  task automatic pulse;
    @(posedge clk_in);
    prog_pulse_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    prog_pulse_out <= 1'b0;
    wait_idle();
  endtask
endmodule

// File: dv/eeprom_program_margin_sequencer_tb.sv
`timescale 1ns/100ps
`include "eeprom_seq_defines.svh"

// ==========================================
// testbench
module eeprom_program_margin_sequencer_tb;
  logic clk, rst_n, cmd_valid, prog_pulse, fault, resp_valid, entered, sm_pd, fail_en;
  logic busy, mmode, pin_o, pin_oe, g;
  logic [15:0] cmd_word, margin_above, resp_word, r;
  logic [4:0] mline;
  int miscompares = 0;
  int comparisons = 0;

  eeprom_program_margin_sequencer uut (
    .clk_in(clk), .rst_n_in(rst_n), .cmd_word_in(cmd_word), .cmd_valid_in(cmd_valid),
    .prog_pulse_in(prog_pulse), .margin_above_in(margin_above), .fault_in(fault),
    .resp_word_out(resp_word), .resp_valid_out(resp_valid), .entered_out(entered),
    .sm_power_down_out(sm_pd), .fail_ind_en_out(fail_en), .busy_out(busy),
    .margin_mode_out(mmode), .margin_line_out(mline),
    .overcurrent_output_two_o_out(pin_o), .overcurrent_output_two_oe_out(pin_oe));

  eeprom_host_model host (
    .clk_in(clk), .resp_word_in(resp_word), .resp_valid_in(resp_valid), .busy_in(busy),
    .cmd_word_out(cmd_word), .cmd_valid_out(cmd_valid), .prog_pulse_out(prog_pulse));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // read command, then no-operation word collects the line
  task automatic rd(input logic [15:0] cmd, input logic [15:0] exp);
    host.send(cmd, g, r);
    host.send(`WORD_NOP, g, r);
    check(g, 16'h0001);
    check(r, exp);
  endtask

  task automatic refresh;
    host.write(16'h83E0, `OP_REFRESH);
    host.wait_idle();
  endtask

  initial
  begin
    rst_n = 1'b0;
    fault = 1'b0;
    margin_above = 16'h0000;
    repeat (3) @(posedge clk);
    check(busy, 16'h0001);
    check(fail_en, 16'h0001);
    rst_n <= 1'b1;
    host.wait_idle();
    host.send(16'h0400, g, r);
    check(g, 16'h0000);
    host.send(`WORD_ENTER, g, r);
    check(g, 16'h0000);
    check(entered, 16'h0001);
    host.write(16'h8250, 16'h8000);
    check(sm_pd, 16'h0001);
    fault <= 1'b1;
    repeat (3) @(posedge clk);
    check(pin_oe, 16'h0001);
    host.write(16'h8010, 16'h0000);
    check(fail_en, 16'h0000);
    check(pin_oe, 16'h0000);
    check(pin_o, 16'h0000);
    fault <= 1'b0;
    rd(16'h0250, 16'h8000);
    rd(16'h0010, 16'h0000);
    rd(16'h0300, 16'h0000);
    host.write(16'h8400, 16'h0000);
    host.write(16'h83E0, `OP_PROG_ZEROS);
    host.pulse();
    host.write(16'h8400, 16'h1234);
    host.write(16'h83E0, `OP_PROG_ONES);
    host.pulse();
    host.write(16'h8400, 16'h0000);
    refresh();
    rd(16'h0400, 16'h1234);
    host.write(16'h8400, 16'h0030);
    host.write(16'h83E0, `OP_PROG_ZEROS);
    refresh();
    rd(16'h0400, 16'h1234);
    host.write(16'h8400, 16'h0030);
    host.write(16'h83E0, `OP_PROG_ZEROS);
    host.pulse();
    refresh();
    rd(16'h0400, 16'h0030);
    margin_above <= 16'hA5C3;
    host.write(16'h83E0, `OP_MARGIN_ONES);
    check(mmode, 16'h0001);
    host.pulse();
    host.write(16'h83E0, `OP_MARGIN_STOP);
    check(mmode, 16'h0000);
    rd(16'h0510, 16'hA5C3);
    rd(16'h0400, 16'hA5C3);
    margin_above <= 16'h5A3C;
    host.write(16'h83E0, `OP_MARGIN_ZEROS);
    check(mmode, 16'h0001);
    host.pulse();
    host.write(16'h83E0, `OP_MARGIN_STOP);
    check(mmode, 16'h0000);
    rd(16'h0400, 16'h5A3C);
    stop_test();
  end

  initial
  begin
    #40000;
    miscompares++;
    stop_test();
  end
endmodule
